/* src/upoc_pkg.sv */
package upoc_pkg;

  // ****************************************
  // port indices and synchroniser depth
  // ****************************************
  localparam int unsigned NUM_PORTS     = 2;
  localparam int unsigned DUAL_ROLE_IDX = 0;
  localparam int unsigned HOST_ONLY_IDX = 1;
  localparam int unsigned SYNC_STAGES   = 2;

  // ****************************************
  // reset levels
  // ****************************************
  localparam logic [1:0] LINE_IDLE  = 2'h3;
  localparam logic [1:0] PORTS_IDLE = 2'h0;

  // ****************************************
  // port state machine
  // ****************************************
  typedef enum logic [1:0] {
    UPOC_OFF,
    UPOC_WAIT_CONN,
    UPOC_ON,
    UPOC_FAULT
  } upoc_state_t;

  // per-port status carried as one unit
  typedef struct packed {
    logic powered;
    logic fault;
    logic fault_pulse;
  } upoc_port_stat_t;

  localparam upoc_port_stat_t STAT_RESET = '{1'b0, 1'b0, 1'b0};

endpackage : upoc_pkg

/* src/upoc_top.sv */
// What this block does
// - drive line low to cut port power
// - release line to grant port power
// - falling edge while enabled raises fault event
// - own low drive never reported as fault
// - detect edge, not persisting low level
// - grant power only after device connection
// - peripheral role senses host bus power
// - role id input sampled active high
// - port 0 dual role, port 1 host only
`timescale 1ns/10ps
`default_nettype none

module upoc_top (
  input  wire logic       mclk,                   // system clock, 40 MHz
  input  wire logic       rst_n,                  // synchronous reset
  input  wire logic [1:0] power_request,          // software wants port on
  input  wire logic [1:0] fault_clear,            // pulse: clear fault
  input  wire logic [1:0] device_connected,       // data-pair attach seen
  input  wire logic [1:0] port_power_enable_fault_n_i, // line level
  output logic      [1:0] port_power_enable_fault_n_o, // line out value
  output logic      [1:0] port_power_enable_fault_n_oe, // drive low
  input  wire logic       host_power_detect,      // pin, host bus power
  input  wire logic       dual_role_id_input,     // pin, role select
  output logic      [1:0] port_powered,           // power granted
  output logic      [1:0] fault_sticky,           // over-current latched
  output logic      [1:0] fault_event,            // pulse per fault edge
  output logic            port0_is_host,          // role of port 0
  output logic            host_power_present,     // peripheral vbus seen
  output logic            bus_power_drive         // port 0 supply wanted
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] line_s1_r;
  logic [1:0] line_s2_r;
  logic [1:0] line_prev_r;
  logic       vbus_s1_r;
  logic       vbus_s2_r;
  logic       id_s1_r;
  logic       id_s2_r;

  // line levels come straight from the pads; two stages before any use,
  // or a slow edge could be seen as a fall in one flop and not another
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      line_s1_r   <= upoc_pkg::LINE_IDLE;
      line_s2_r   <= upoc_pkg::LINE_IDLE;
      line_prev_r <= upoc_pkg::LINE_IDLE;
    end else begin
      line_s1_r   <= port_power_enable_fault_n_i;
      line_s2_r   <= line_s1_r;
      line_prev_r <= line_s2_r;
    end
  end

  // ****************************************
  // role and host power synchronisers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vbus_s1_r <= 1'b0;
      vbus_s2_r <= 1'b0;
      id_s1_r   <= 1'b0;
      id_s2_r   <= 1'b0;
    end else begin
      vbus_s1_r <= host_power_detect;
      vbus_s2_r <= vbus_s1_r;
      id_s1_r   <= dual_role_id_input;
      id_s2_r   <= id_s1_r;
    end
  end

  // ****************************************
  // role selection
  // ****************************************
  // id high selects host; port 1 is always host
  wire logic       role_host0 = id_s2_r;
  wire logic [1:0] role_host  = {1'b1, role_host0};

  // ****************************************
  // line edge detection
  // ****************************************
  // a fall of the synchronised line; it is only acted on while the
  // port is released, so the module's own low drive never counts
  wire logic [1:0] line_fall  = line_prev_r & ~line_s2_r;

  // ****************************************
  // per-port power control
  // ****************************************
  upoc_pkg::upoc_port_stat_t stat [upoc_pkg::NUM_PORTS];

  genvar gi;
  generate
    for (gi = 0; gi < upoc_pkg::NUM_PORTS; gi++) begin : g_port
      upoc_pkg::upoc_state_t st_r;
      upoc_pkg::upoc_state_t st_nxt;
      logic                  fault_r;
      logic                  pulse_r;
      logic                  drive_low_r;
      logic                  settle_r;

      // ****************************************
      // per-port decodes
      // ****************************************
      wire logic is_on      = (st_r == upoc_pkg::UPOC_ON);
      wire logic line_high  = line_s2_r[gi];
      wire logic attach     = device_connected[gi];
      wire logic clear      = fault_clear[gi];
      // port 0 only asks for power while the id pin says host
      wire logic want       = power_request[gi] && role_host[gi];

      // edge only counts once power was released and line settled high;
      // the switch lets go of the flag soon after it trips, so a level
      // test would miss short pulses
      wire logic armed      = is_on && settle_r;
      wire logic oc_edge    = armed && line_fall[gi];

      // a tripped port stays cut until software clears it with its
      // request withdrawn, so a shorted load cannot retry on its own
      wire logic leave_flt  = clear && !want;

      // set wins over clear
      wire logic fault_nxt  = oc_edge | (fault_r & ~clear);
      // low drive cuts power, release grants it
      wire logic drive_nxt  = (st_nxt != upoc_pkg::UPOC_ON);
      wire logic settle_nxt = is_on && line_high;
      wire logic powered    = is_on && !drive_low_r;

      // ****************************************
      // port state machine
      // ****************************************
      // off, then wait for attach, then on; a fault edge parks it
      always_comb begin
        st_nxt = st_r;
        unique case (st_r)
          upoc_pkg::UPOC_OFF:
            if (want) st_nxt = upoc_pkg::UPOC_WAIT_CONN;
          upoc_pkg::UPOC_WAIT_CONN:
            if (!want) st_nxt = upoc_pkg::UPOC_OFF;
            else if (attach)
              st_nxt = upoc_pkg::UPOC_ON;
          upoc_pkg::UPOC_ON:
            if (oc_edge) st_nxt = upoc_pkg::UPOC_FAULT;
            else if (!want) st_nxt = upoc_pkg::UPOC_OFF;
          upoc_pkg::UPOC_FAULT:
            if (leave_flt) st_nxt = upoc_pkg::UPOC_OFF;
        endcase
      end

      // ****************************************
      // port registers
      // ****************************************
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          st_r        <= upoc_pkg::UPOC_OFF;
          fault_r     <= 1'b0;
          pulse_r     <= 1'b0;
          // reset keeps every port unpowered until asked
          drive_low_r <= 1'b1;
          settle_r    <= 1'b0;
        end else begin
          st_r        <= st_nxt;
          fault_r     <= fault_nxt;
          pulse_r     <= oc_edge;
          drive_low_r <= drive_nxt;
          settle_r    <= settle_nxt;
        end
      end

      assign stat[gi] = '{powered, fault_r, pulse_r};
      // open drain: the value is always low, only the enable moves
      assign port_power_enable_fault_n_oe[gi] = drive_low_r;
      assign port_power_enable_fault_n_o[gi]  = 1'b0;
    end
  endgenerate

  // ****************************************
  // registered port status outputs
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port_powered <= upoc_pkg::PORTS_IDLE;
      fault_sticky <= upoc_pkg::PORTS_IDLE;
      fault_event  <= upoc_pkg::PORTS_IDLE;
    end else begin
      port_powered <= {stat[1].powered, stat[0].powered};
      fault_sticky <= {stat[1].fault, stat[0].fault};
      fault_event  <= {stat[1].fault_pulse, stat[0].fault_pulse};
    end
  end

  // ****************************************
  // registered role outputs
  // ****************************************
  // host power only matters while port 0 acts as a peripheral
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port0_is_host      <= 1'b0;
      host_power_present <= 1'b0;
      bus_power_drive    <= 1'b0;
    end else begin
      port0_is_host      <= role_host0;
      host_power_present <= !role_host0 && vbus_s2_r;
      // port 0 supply is wanted only as host with power granted
      bus_power_drive    <= role_host0 && stat[0].powered;
    end
  end

endmodule : upoc_top

`default_nettype wire

/* dv/upoc_switch_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// carrier power switch, enable and flag tied
// ********
module upoc_switch_model (
  input  wire logic       mclk,     // clock
  input  wire logic [1:0] line,     // shared line level
  input  wire logic [1:0] trip,     // overload command
  output logic      [1:0] flag_n_oe // flag pulls line low
);
  logic [3:0] cnt_r = 4'h0;
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (trip[i] && line[i]) begin
        cnt_r[2*i+:2] <= 2'h2;
      end else if (cnt_r[2*i+:2] != 2'h0) begin
        cnt_r[2*i+:2] <= cnt_r[2*i+:2] - 2'h1;
      end
    end
  end
  assign flag_n_oe = {|cnt_r[3:2], |cnt_r[1:0]};
endmodule : upoc_switch_model
`default_nettype wire

/* dv/upoc_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// port checks
// ********
module upoc_asserts (
  input wire logic       mclk,   // clock
  input wire logic       rst_n,  // reset
  input wire logic [1:0] device_connected,             // attach
  input wire logic [1:0] port_power_enable_fault_n_o,  // value
  input wire logic [1:0] port_power_enable_fault_n_oe, // drive
  input wire logic [1:0] port_powered,       // granted
  input wire logic [1:0] fault_sticky,       // latched
  input wire logic [1:0] fault_event,        // pulse
  input wire logic       port0_is_host,      // role
  input wire logic       dual_role_id_input, // pin
  input wire logic       host_power_present  // vbus
);
  wire [1:0] oe = port_power_enable_fault_n_oe;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_pull_low: assert property (port_power_enable_fault_n_o == 2'h0)
    else $error("line value not low");
  a_grant_after: assert property ($fell(oe[1]) |=> port_powered[1])
    else $error("power not granted");
  a_conn_first: assert property
    ($fell(oe[1]) |-> $past(device_connected[1]))
    else $error("released before attach");
  a_event_once: assert property (fault_event[1] |=> !fault_event[1])
    else $error("event too long");
  a_event_latch: assert property (fault_event[1] |-> fault_sticky[1] && oe[1])
    else $error("fault not latched");
  a_own_low: assert property (fault_event[1] |-> !$past(oe[1], 2))
    else $error("own drive flagged");
  a_role_id: assert property
    ($rose(port0_is_host) |-> $past(dual_role_id_input, 3))
    else $error("role not from id");
  a_host_pwr: assert property (host_power_present |-> !port0_is_host)
    else $error("vbus seen as host");
  a_dual_role: assert property ($rose(port_powered[0]) |-> port0_is_host)
    else $error("port 0 powered as peripheral");
endmodule : upoc_asserts
bind upoc_top upoc_asserts u_chk (.*);
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       id = 1'b0;
  logic       vbus = 1'b0;
  logic [1:0] req = 2'h0, clr = 2'h0, conn = 2'h0, trip = 2'h0;
  wire  [1:0] line, o, oe, sw_oe, pwr, stk, evt;
  wire        is_host, vpres, drv;
  int         errors = 0, check_count = 0, cyc = 0;
  assign line = ~((oe & ~o) | sw_oe);
  upoc_top uut (.mclk, .rst_n, .power_request(req), .fault_clear(clr),
    .device_connected(conn), .port_power_enable_fault_n_i(line),
    .port_power_enable_fault_n_o(o), .port_power_enable_fault_n_oe(oe),
    .host_power_detect(vbus), .dual_role_id_input(id),
    .port_powered(pwr), .fault_sticky(stk), .fault_event(evt),
    .port0_is_host(is_host), .host_power_present(vpres),
    .bus_power_drive(drv));
  upoc_switch_model u_sw (.mclk, .line, .trip, .flag_n_oe(sw_oe));
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 3000) begin errors++; end_of_test(); end
  task automatic chk(input logic [1:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin errors++; $display("BAD %0t %s", $time, m); end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick
  task automatic end_of_test;
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic t_power;
    chk(oe, 2'h3, "reset drive");
    chk(o, 2'h0, "line value");
    req = 2'h3;
    tick(3);
    chk(oe, 2'h3, "released early");
    conn = 2'h3;
    tick(3);
    chk(oe, 2'h1, "port 1 release");
    chk(pwr, 2'h2, "port 0 refused");
    tick(6);
  endtask : t_power
  task automatic t_fault;
    trip = 2'h2;
    tick(1);
    trip = 2'h0;
    for (int i = 0; i < 10 && evt[1] !== 1'b1; i++) tick(1);
    chk(evt, 2'h2, "fault event");
    chk(stk, 2'h2, "sticky fault");
    chk(oe, 2'h3, "power cut");
    req = 2'h0;
    clr = 2'h2;
    tick(2);
    clr = 2'h0;
    chk(stk, 2'h0, "fault cleared");
  endtask : t_fault
  task automatic t_role;
    vbus = 1'b1;
    tick(5);
    chk({vpres, is_host}, 2'h2, "peripheral vbus");
    id = 1'b1;
    req = 2'h1;
    tick(8);
    chk({vpres, is_host}, 2'h1, "host role");
    chk(pwr, 2'h1, "port 0 host");
    chk({1'b0, drv}, 2'h1, "bus drive");
  endtask : t_role
  initial begin
    tick(12);
    rst_n = 1'b1;
    t_power();
    t_fault();
    t_role();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
